/* File: verilog/ipc_defines.vh */
`ifndef IPC_DEFINES_VH
`define IPC_DEFINES_VH

// register map (indices of the power mode control, status and wake configuration registers)
`define IPC_PMC_ADDR        4'h0
`define IPC_STAT_ADDR       4'h1
`define IPC_WAKE_ADDR       4'h2

// power_mode_control field positions
`define IPC_BIT_BAUD        7
`define IPC_BIT_FLAG_HI     3
`define IPC_BIT_FLAG_LO     2
`define IPC_BIT_DEEP        1
`define IPC_BIT_SLEEP       0
`define IPC_PMC_RESET       8'h00
`define IPC_PMC_WMASK       8'h8F

// wake configuration bits
`define IPC_BIT_EN_A        0
`define IPC_BIT_EN_B        1

// timing
`define IPC_OSC_PER_MC      12
`define IPC_RESET_MC        2
`define IPC_RESET_CYCLES    (`IPC_OSC_PER_MC * `IPC_RESET_MC)
`define IPC_STAB_CYCLES     256

`endif

/* File: verilog/ipc_reset_filter.v */
`timescale 1ns/1ps
`include "ipc_defines.vh"

// ----------------------------------------------------------------
// reset pin qualifier: high for the full hold count gives a pulse
// ----------------------------------------------------------------
module ipc_reset_filter #(
   parameter HOLD = `IPC_RESET_CYCLES
) (
   // clock and reset
   input  wire       ref_clk,
   input  wire       reset,
   // pin and result
   input  wire       rst_pin,
   output reg        rst_hit_q
);

   reg  [7:0]  cnt_q;

   // count consecutive high samples; one pulse per held assertion
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cnt_q     <= 8'h00;
         rst_hit_q <= 1'b0;
      end else if (!rst_pin) begin
         cnt_q     <= 8'h00;
         rst_hit_q <= 1'b0;
      end else begin
         rst_hit_q <= (cnt_q == HOLD[7:0] - 8'h01);
         if (cnt_q != HOLD[7:0])
            cnt_q <= cnt_q + 8'h01;
      end
   end

endmodule

/* File: verilog/ipc_ale_gen.v */
`timescale 1ns/1ps
`include "ipc_defines.vh"

// ----------------------------------------------------------------
// address latch strobe: one pulse every six oscillator periods
// ----------------------------------------------------------------
module ipc_ale_gen #(
   parameter DIV = `IPC_OSC_PER_MC / 2
) (
   // clock and reset
   input  wire       ref_clk,
   input  wire       reset,
   // control
   input  wire       run,
   output reg        ale_q
);

   reg  [3:0]  div_q;

   // frozen while not running so the phase resumes cleanly
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         div_q <= 4'h0;
         ale_q <= 1'b0;
      end else if (run) begin
         div_q <= (div_q == DIV[3:0] - 4'h1) ? 4'h0 : div_q + 4'h1;
         ale_q <= (div_q == 4'h0);
      end else begin
         ale_q <= 1'b0;
      end
   end

endmodule

/* File: verilog/ipc_power_ctrl.v */
// Functional notes
// - idle gates cpu clock, peripherals keep running
// - power-down stops oscillator after requesting instruction
// - bit7 baud select, bits3/2 software flags
// - bits 6..4 reserved, read as zero
// - bit1 power-down request, cleared by wake interrupt/reset
// - bit0 idle request, cleared by interrupt/reset
// - reset value zero, no bit access
// - setting instruction is last before idle
// - cpu state kept during idle
// - idle holds ports, strobes driven high
// - enabled interrupt ends idle, resumes after
// - reset of two machine cycles ends idle
// - ram and registers kept in power-down
// - only enabled external pins wake power-down; osc_run still restarts on any low wake pin, enabled or not
// - low pin restarts oscillator, high completes
// - either pin restarts, first release exits
// - resume after instruction that requested power-down
// - reset exit reinitialises registers, irq exit keeps
// - both bits set: power-down exit, clear both
// - power-down: strobes low, port0 floats, ports keep
// - address strobe at one sixth oscillator rate
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "ipc_defines.vh"

module ipc_power_ctrl #(
   parameter STAB_CYCLES = `IPC_STAB_CYCLES
) (
   // clock and reset
   input  wire       ref_clk,
   input  wire       reset,
   // register port
   input  wire [3:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   // reset pin and interrupts
   input  wire       rst_pin,
   input  wire       irq_pending,
   input  wire       wake_irq_a,
   input  wire       wake_irq_b,
   // cpu side
   input  wire       instr_done,
   output wire       cpu_clk_en,
   output wire       periph_clk_en,
   output wire       osc_run,
   output wire       sfr_reinit,
   output wire       irq_vector_a,
   output wire       irq_vector_b,
   // pin control
   output wire       ale_out,
   output wire       code_fetch_strobe,
   input  wire       fetch_strobe_cpu,
   output wire       port_hold,
   output wire       port0_oe_n,
   output wire       baud_double_select
);

   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   localparam [4:0] ST_RUN   = 5'h01;
   localparam [4:0] ST_IDLE  = 5'h02;
   localparam [4:0] ST_DEEP  = 5'h04;
   localparam [4:0] ST_STAB  = 5'h08;
   localparam [4:0] ST_REL   = 5'h10;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg  [7:0]  pmc_q;
   reg  [1:0]  wake_en_q;
   reg  [4:0]  state_q;
   reg  [4:0]  state_d;
   reg  [15:0] stab_q;
   reg         pend_wr_q;
   reg  [1:0]  vec_q;
   wire        rst_hit;
   wire        ale_pulse;
   wire        pin_low;
   wire        any_low;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function [7:0] pmc_view;
      input [7:0] v;
      begin
         pmc_view = v & `IPC_PMC_WMASK; // reserved bits read zero
      end
   endfunction

   // ----------------------------------------------------------------
   // reset qualifier and strobe generator
   // ----------------------------------------------------------------
   ipc_reset_filter #(
      .HOLD      (`IPC_RESET_CYCLES)
   ) u_rst (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .rst_pin   (rst_pin),
      .rst_hit_q (rst_hit)
   );

   ipc_ale_gen #(
      .DIV       (`IPC_OSC_PER_MC / 2)
   ) u_ale (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .run       (state_q == ST_RUN),
      .ale_q     (ale_pulse)
   );

   // enabled wake pins that are low, and any wake pin that is low
   assign pin_low = (wake_en_q[`IPC_BIT_EN_A] & ~wake_irq_a) |
                    (wake_en_q[`IPC_BIT_EN_B] & ~wake_irq_b);
   assign any_low = ~wake_irq_a | ~wake_irq_b;

   // ----------------------------------------------------------------
   // mode sequencer
   // ----------------------------------------------------------------
   // request takes effect after the writing instruction completes
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (pend_wr_q && instr_done) begin
               if (pmc_q[`IPC_BIT_DEEP])
                  state_d = ST_DEEP;
               else if (pmc_q[`IPC_BIT_SLEEP])
                  state_d = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (irq_pending)
               state_d = ST_RUN;
         end
         ST_DEEP: begin
            if (pin_low)
               state_d = ST_STAB;
         end
         ST_STAB: begin
            if (stab_q == 16'h0000)
               state_d = ST_REL;
         end
         ST_REL: begin
            if (vec_q != 2'b00)
               state_d = ST_RUN;
         end
         default: state_d = ST_RUN;
      endcase
      if (rst_hit)
         state_d = ST_RUN;
   end

   always @(posedge ref_clk or posedge reset) begin
      if (reset)
         state_q <= ST_RUN;
      else
         state_q <= state_d;
   end

   // stabilisation counter runs only while oscillator restarts
   always @(posedge ref_clk or posedge reset) begin
      if (reset)
         stab_q <= 16'h0000;
      else if (state_q == ST_DEEP)
         stab_q <= STAB_CYCLES[15:0];
      else if (state_q == ST_STAB && stab_q != 16'h0000)
         stab_q <= stab_q - 16'h0001;
   end

   // first enabled pin to return high picks the vector, a first
   always @* begin
      vec_q = 2'b00;
      if (state_q == ST_REL) begin
         if (wake_en_q[`IPC_BIT_EN_A] && wake_irq_a)
            vec_q = 2'b01;
         else if (wake_en_q[`IPC_BIT_EN_B] && wake_irq_b)
            vec_q = 2'b10;
      end
   end

   assign irq_vector_a = vec_q[0];
   assign irq_vector_b = vec_q[1];

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   // hardware clear of sleep bits; a same-cycle write loses to exit
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pmc_q     <= `IPC_PMC_RESET;
         wake_en_q <= 2'b00;
         pend_wr_q <= 1'b0;
      end else if (rst_hit) begin
         pmc_q     <= `IPC_PMC_RESET;
         wake_en_q <= 2'b00;
         pend_wr_q <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == `IPC_PMC_ADDR) begin
            pmc_q     <= pmc_view(reg_wdata);
            pend_wr_q <= 1'b1;
         end else if (instr_done) begin
            pend_wr_q <= 1'b0;
         end
         if (reg_wr && reg_addr == `IPC_WAKE_ADDR)
            wake_en_q <= reg_wdata[1:0];
         if (state_q == ST_IDLE && irq_pending)
            pmc_q[`IPC_BIT_SLEEP] <= 1'b0;
         if (state_q == ST_REL && vec_q != 2'b00) begin
            pmc_q[`IPC_BIT_SLEEP] <= 1'b0;
            pmc_q[`IPC_BIT_DEEP]  <= 1'b0;
         end
      end
   end

   // read data one cycle after the strobe
   always @(posedge ref_clk or posedge reset) begin
      if (reset)
         reg_rdata <= 8'h00;
      else if (reg_rd) begin
         case (reg_addr)
            `IPC_PMC_ADDR:  reg_rdata <= pmc_view(pmc_q);
            `IPC_STAT_ADDR: reg_rdata <= {3'h0, state_q};
            `IPC_WAKE_ADDR: reg_rdata <= {6'h00, wake_en_q};
            default:        reg_rdata <= 8'h00;
         endcase
      end else
         reg_rdata <= 8'h00;
   end

   // ----------------------------------------------------------------
   // clock gates and pins
   // ----------------------------------------------------------------
   // cpu frozen outside run; its registers simply hold
   assign cpu_clk_en    = (state_q == ST_RUN);
   assign periph_clk_en = (state_q == ST_RUN) | (state_q == ST_IDLE);
   assign osc_run       = ~(state_q == ST_DEEP) | any_low;
   // ram/registers untouched while deep
   assign sfr_reinit    = rst_hit;

   assign ale_out = (state_q == ST_IDLE) ? 1'b1 :
                    (state_q == ST_RUN)  ? ale_pulse : 1'b0;
   assign code_fetch_strobe = (state_q == ST_IDLE) ? 1'b1 :
                              (state_q == ST_RUN) ? fetch_strobe_cpu : 1'b0;
   assign port_hold  = (state_q != ST_RUN);
   assign port0_oe_n = (state_q != ST_RUN);
   assign baud_double_select = pmc_q[`IPC_BIT_BAUD];

endmodule

/* File: tb/ipc_power_checker.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// power mode checker
// ----------------------------------------------------------------
module ipc_power_checker (
   // clock and reset
   input wire       ref_clk,
   input wire       reset,
   // register port
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   // external pins
   input wire       rst_pin,
   input wire       wake_irq_a,
   input wire       wake_irq_b,
   // mode outputs
   input wire       cpu_clk_en,
   input wire       periph_clk_en,
   input wire       osc_run,
   input wire       sfr_reinit,
   input wire       irq_vector_a,
   input wire       irq_vector_b,
   input wire       ale_out,
   input wire       code_fetch_strobe,
   input wire       port_hold,
   input wire       port0_oe_n,
   input wire       baud_double_select
);
   reg [4:0] hi_cnt_q;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // consecutive high samples of the reset pin, saturating so long holds stay legal
   always @(posedge ref_clk or posedge reset) begin
      if (reset)
         hi_cnt_q <= 5'h00;
      else if (!rst_pin)
         hi_cnt_q <= 5'h00;
      else if (hi_cnt_q != 5'h1F)
         hi_cnt_q <= hi_cnt_q + 5'h01;
   end
   idle_pins_a: assert property (periph_clk_en && !cpu_clk_en |-> ale_out &&
      code_fetch_strobe && port_hold) else $error("idle pin states wrong");
   deep_pins_a: assert property (!periph_clk_en |-> !cpu_clk_en && !ale_out &&
      !code_fetch_strobe && port0_oe_n) else $error("power-down pin states wrong");
   osc_stop_a: assert property (!osc_run |-> !periph_clk_en && wake_irq_a &&
      wake_irq_b) else $error("oscillator stopped outside power-down");
   run_pins_a: assert property (cpu_clk_en |-> periph_clk_en && !port_hold &&
      !port0_oe_n) else $error("run mode pin states wrong");
   ale_rate_a: assert property (ale_out && cpu_clk_en ##1 cpu_clk_en[*6] |->
      ale_out && !$past(ale_out)) else $error("address strobe rate wrong");
   rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
   baud_wr_a: assert property ($past(reg_wr) && $past(reg_addr) == 4'h0 |->
      baud_double_select == $past(reg_wdata[7])) else $error("baud select not written");
   reset_len_a: assert property (sfr_reinit |-> hi_cnt_q >= 5'h18 ||
      $past(hi_cnt_q) >= 5'h18) else $error("reset taken too early");
   rst_exit_a: assert property (sfr_reinit |-> ##[0:2] cpu_clk_en)
      else $error("no return to run after reset");
   vec_exit_a: assert property (irq_vector_a |-> wake_irq_a ##1 cpu_clk_en)
      else $error("wake vector without release or resume");
   vec_b_exit_a: assert property (irq_vector_b |-> wake_irq_b && !irq_vector_a
      ##1 cpu_clk_en) else $error("second wake vector without release or resume");
endmodule

bind ipc_power_ctrl ipc_power_checker i_chk (.*);

/* File: tb/ipc_ext_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// reset circuit and external wake sources
// ----------------------------------------------------------------
module ipc_ext_model (
   // clock
   input  wire ref_clk,
   // driven pins
   output reg  rst_pin,
   output reg  wake_irq_a,
   output reg  wake_irq_b
);
   // pull-down on the reset line, pull-ups on the wake lines
   initial begin
      rst_pin = 1'b0;
      wake_irq_a = 1'b1;
      wake_irq_b = 1'b1;
   end
   // reset held high for exactly n samples, so a longer filter is caught
   task hold_reset(input int n);
      @(posedge ref_clk);
      rst_pin <= 1'b1;
      repeat (n) @(posedge ref_clk);
      rst_pin <= 1'b0;
   endtask
   // level on one wake line, held until told otherwise
   task set_wake(input logic b, input logic lvl);
      @(posedge ref_clk);
      if (b)
         wake_irq_b <= lvl;
      else
         wake_irq_a <= lvl;
   endtask
endmodule

/* File: tb/idle_powerdown_controller_tb.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// power mode controller bench
// ----------------------------------------------------------------
module idle_powerdown_controller_tb;
   logic       ref_clk = 1'b0;
   logic       reset = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       irq_pending = 1'b0;
   logic       instr_done = 1'b0;
   logic       fetch_strobe_cpu = 1'b0;
   wire  [7:0] reg_rdata;
   wire        rst_pin, wake_irq_a, wake_irq_b, cpu_clk_en, periph_clk_en, osc_run;
   wire        ale_out, code_fetch_strobe, port_hold, port0_oe_n, baud_double_select;
   int         n_fail = 0;
   int         checks_done = 0;
   int         cycles = 0;
   ipc_power_ctrl #(.STAB_CYCLES(8)) i_dut (.ref_clk(ref_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rst_pin(rst_pin), .irq_pending(irq_pending),
      .wake_irq_a(wake_irq_a), .wake_irq_b(wake_irq_b), .instr_done(instr_done),
      .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_run(osc_run),
      .sfr_reinit(), .irq_vector_a(), .irq_vector_b(), .ale_out(ale_out),
      .code_fetch_strobe(code_fetch_strobe), .fetch_strobe_cpu(fetch_strobe_cpu),
      .port_hold(port_hold), .port0_oe_n(port0_oe_n), .baud_double_select(baud_double_select));
   ipc_ext_model i_ext (.ref_clk(ref_clk), .rst_pin(rst_pin), .wake_irq_a(wake_irq_a),
      .wake_irq_b(wake_irq_b));
   // 100 MHz clock
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   // hang guard, far above the few hundred cycles the tests need
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         report_and_stop;
      end
   end
   task report_and_stop;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task rchk(input logic [3:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   // one completed instruction takes the pending mode request
   task step;
      @(posedge ref_clk);
      instr_done <= 1'b1;
      @(posedge ref_clk);
      instr_done <= 1'b0;
      #1;
   endtask
   task wait_run(input int n);
      repeat (n) if (cpu_clk_en !== 1'b1) @(posedge ref_clk);
      #1;
   endtask
   task t_regs;
      rchk(4'h0, 8'h00);
      rchk(4'h1, 8'h01);
      wr(4'h0, 8'hFC);
      rchk(4'h0, 8'h8C);
      chk({7'h00, baud_double_select}, 8'h01);
      wr(4'hF, 8'hFF);
      rchk(4'hF, 8'h00);
      wr(4'h0, 8'h00);
      $display("t_regs done");
   endtask
   task t_idle;
      wr(4'h0, 8'h0D);
      step;
      chk({4'h0, ale_out, code_fetch_strobe, cpu_clk_en, periph_clk_en}, 8'h0D);
      rchk(4'h1, 8'h02);
      @(posedge ref_clk);
      irq_pending <= 1'b1;
      wait_run(4);
      irq_pending <= 1'b0;
      rchk(4'h0, 8'h0C);
      wr(4'h0, 8'h05);
      step;
      i_ext.hold_reset(24);
      wait_run(4);
      rchk(4'h0, 8'h00);
      $display("t_idle done");
   endtask
   task t_deep;
      wr(4'h2, 8'h01);
      wr(4'h0, 8'h03);
      step;
      chk({4'h0, ale_out, code_fetch_strobe, port0_oe_n, osc_run}, 8'h02);
      rchk(4'h1, 8'h04);
      i_ext.set_wake(1'b1, 1'b0);
      repeat (12) @(posedge ref_clk);
      rchk(4'h1, 8'h04);
      i_ext.set_wake(1'b1, 1'b1);
      i_ext.set_wake(1'b0, 1'b0);
      repeat (4) @(posedge ref_clk);
      rchk(4'h1, 8'h08);
      repeat (12) @(posedge ref_clk);
      rchk(4'h1, 8'h10);
      i_ext.set_wake(1'b0, 1'b1);
      wait_run(8);
      rchk(4'h0, 8'h00);
      rchk(4'h2, 8'h01);
      $display("t_deep done");
   endtask
   task t_both;
      wr(4'h2, 8'h03);
      wr(4'h0, 8'h02);
      step;
      i_ext.set_wake(1'b1, 1'b0);
      i_ext.set_wake(1'b0, 1'b0);
      repeat (16) @(posedge ref_clk);
      i_ext.set_wake(1'b1, 1'b1);
      wait_run(8);
      chk({7'h00, cpu_clk_en}, 8'h01);
      i_ext.set_wake(1'b0, 1'b1);
      wr(4'h0, 8'h86);
      step;
      i_ext.hold_reset(24);
      wait_run(4);
      rchk(4'h0, 8'h00);
      rchk(4'h2, 8'h00);
      $display("t_both done");
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      t_regs;
      t_idle;
      t_deep;
      t_both;
      report_and_stop;
   end
endmodule
